// [bench/dcf_far_model.sv]
/* Consumer side: resolves the read data bus and ties the cascade inputs low.
   Assumes one stand-alone device on the shared clock. */
`timescale 1ns/10ps
module dcf_far_model (
    input  wire logic        pclk,
    input  wire logic [17:0] rd_data,
    input  wire logic        rd_data_oe,
    output logic      [17:0] rd_bus,
    output logic             write_cascade_in,
    output logic             read_cascade_in
);
    logic [17:0] hold_ff;
    assign write_cascade_in = 1'b0;
    assign read_cascade_in  = 1'b0;
    // released bus shows a toggling pattern
    assign rd_bus = rd_data_oe ? rd_data : hold_ff;
    always_ff @(posedge pclk) begin
        hold_ff <= rd_data_oe ? ~rd_data : ~hold_ff;
    end
endmodule

// [bench/dcf_fifo_assertions.sv]
/* Checker of buffer flags, output enable and register answer, bound to dcf_fifo.
   Assumes stand-alone use while words move, and pclk as the only clock. */
`timescale 1ns/10ps
module dcf_fifo_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic master_reset_n,
    input wire logic wr_en_n,
    input wire logic rd_en_n,
    input wire logic out_en_n,
    input wire logic offset_load_n,
    input wire logic flag_sync_select,
    input wire logic first_load_retransmit,
    input wire logic rd_data_oe,
    input wire logic write_cascade_out_half_full,
    input wire logic empty_flag_n,
    input wire logic full_flag_n,
    input wire logic almost_empty_flag_n,
    input wire logic almost_full_flag_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_oe; 1 |=> rd_data_oe == !$past(out_en_n); endproperty
    a_oe: assert property (p_oe) else $error("oe not following pin");
    property p_mrst; !master_reset_n |=> !empty_flag_n && !almost_empty_flag_n && full_flag_n && almost_full_flag_n;
    endproperty
    a_mrst: assert property (p_mrst) else $error("flags after reset");
    property p_wr; !empty_flag_n && !wr_en_n && rd_en_n && offset_load_n && master_reset_n |=> empty_flag_n;
    endproperty
    a_wr: assert property (p_wr) else $error("write to empty missed");
    property p_emp; !empty_flag_n && wr_en_n && !first_load_retransmit |=> !empty_flag_n; endproperty
    a_emp: assert property (p_emp) else $error("empty left without write");
    property p_full; !full_flag_n && rd_en_n && master_reset_n && !first_load_retransmit |=> !full_flag_n;
    endproperty
    a_full: assert property (p_full) else $error("full left without read");
    property p_rd;
        !full_flag_n && !rd_en_n && wr_en_n && offset_load_n && master_reset_n && !first_load_retransmit
        |=> full_flag_n;
    endproperty
    a_rd: assert property (p_rd) else $error("read from full missed");
    property p_ae; !empty_flag_n && (flag_sync_select || $past(!empty_flag_n)) |-> !almost_empty_flag_n; endproperty
    a_ae: assert property (p_ae) else $error("no almost empty at empty");
    property p_af; !full_flag_n && (flag_sync_select || $past(!full_flag_n)) |-> !almost_full_flag_n; endproperty
    a_af: assert property (p_af) else $error("no almost full at full");
    property p_hf; !full_flag_n |-> !write_cascade_out_half_full; endproperty
    a_hf: assert property (p_hf) else $error("no half full at full");
    property p_apb; psel && !penable |=> pready ##1 !pready; endproperty
    a_apb: assert property (p_apb) else $error("pready not one cycle after setup");
endmodule
bind dcf_fifo dcf_fifo_assertions u_chk (.pclk, .presetn, .psel, .penable, .pready, .master_reset_n, .wr_en_n,
    .rd_en_n, .out_en_n, .offset_load_n, .flag_sync_select, .first_load_retransmit, .rd_data_oe,
    .write_cascade_out_half_full, .empty_flag_n, .full_flag_n, .almost_empty_flag_n, .almost_full_flag_n);

// [bench/dcf_fifo_test.sv]
/* Self-checking bench of dcf_fifo: a storage and offset model queues expected results.
   Assumes a 16-word instance, small offset defaults, stand-alone use. */
`timescale 1ns/10ps
module dcf_fifo_test;
    localparam int          DEP = 16;
    localparam logic [17:0] AER = 18'h00002;
    localparam logic [17:0] AFR = 18'h00002;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, master_reset_n, wr_en_n, rd_en_n;
    logic        out_en_n, rd_data_oe, offset_load_n, flag_sync_select, first_load_retransmit, er, wp, rp;
    logic        wci, rci, rco, hf_n, ef_n, ff_n, ae_n, af_n;
    logic [7:0]  paddr;
    logic [17:0] wr_data, rd_data, rd_bus, lastd, mq[$], hist[$], ofs[2];
    logic [31:0] pwdata, prdata, eq[$], rv, mv, seed;
    int          error_cnt, num_checks, i;
    dcf_fifo #(.DEPTH(DEP), .ADDR_W(4), .AE_OFS_RST(AER), .AF_OFS_RST(AFR)) uut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .master_reset_n, .wr_en_n, .wr_data, .rd_en_n,
        .out_en_n, .rd_data, .rd_data_oe, .offset_load_n, .flag_sync_select, .first_load_retransmit,
        .write_cascade_in(wci), .read_cascade_in(rci), .read_cascade_out(rco), .write_cascade_out_half_full(hf_n),
        .empty_flag_n(ef_n), .full_flag_n(ff_n), .almost_empty_flag_n(ae_n), .almost_full_flag_n(af_n));
    dcf_far_model u_far (.pclk, .rd_data, .rd_data_oe, .rd_bus, .write_cascade_in(wci), .read_cascade_in(rci));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // expected flags after an edge; almost flags lag with strap low
    function automatic logic [31:0] flags(input logic oen, input int sz0);
        int sz;
        int a;
        sz = mq.size();
        a = flag_sync_select ? sz : sz0;
        return {26'h0, !oen, sz != 0, !(a <= ofs[0]), !(sz > DEP / 2), !(DEP - a <= ofs[1]), sz != DEP};
    endfunction
    // op bits: buffer reset, retransmit, offset load, read, write
    task automatic cyc(input logic [4:0] op, input logic [17:0] d);
        logic [31:0] r;
        logic [17:0] wd;
        int          sz0;
        r = rnd();
        wd = op[2] ? d : r[18:1];
        sz0 = mq.size();
        master_reset_n <= !op[4];
        first_load_retransmit <= op[3];
        offset_load_n <= !op[2];
        rd_en_n <= !op[1];
        wr_en_n <= !op[0];
        wr_data <= wd;
        out_en_n <= r[0];
        if (op[4]) begin
            mq = {};
            hist = {};
            ofs = '{AER, AFR};
            wp = 1'b0;
            rp = 1'b0;
            sz0 = 0;
        end else if (op[2]) begin
            if (op[1]) begin
                lastd = ofs[rp];
                rp = !rp;
            end
            if (op[0]) begin
                ofs[wp] = wd;
                wp = !wp;
            end
        end else begin
            if (op[3]) mq = hist;
            if (op[1] && !op[3] && sz0 > 0) lastd = mq.pop_front();
            if (op[0] && sz0 < DEP) begin
                mq.push_back(wd);
                hist.push_back(wd);
            end
        end
        @(posedge pclk);
        if (op[1] && !op[4]) eq.push_back({14'h0, lastd});
        eq.push_back(flags(r[0], sz0) | 32'h80000000);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 9; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rv = prdata;
        er = pslverr;
        penable <= 1'b0;
        if (i == 9) begin
            error_cnt++;
            end_sim();
        end
    endtask
    always @(negedge pclk) begin
        while (eq.size() > 0) begin
            mv = eq.pop_front();
            if (mv[31]) begin
                chk("flags", {26'h0, mv[5:0]}, {25'h0, rco, rd_data_oe, ef_n, ae_n, hf_n, af_n, ff_n});
            end else begin
                chk("data", mv, {14'h0, rd_data});
                if (rd_data_oe === 1'b1) chk("bus", {14'h0, rd_data}, {14'h0, rd_bus});
            end
        end
    end
    initial begin
        repeat (50000) @(posedge pclk);
        error_cnt++;
        end_sim();
    end
    initial begin
        seed = 32'hE94695C2;
        {presetn, psel, penable, pwrite, paddr, pwdata, wr_data} = '0;
        {master_reset_n, wr_en_n, rd_en_n, out_en_n, offset_load_n, flag_sync_select} = 6'h3F;
        first_load_retransmit = 1'b0;
        ofs = '{AER, AFR};
        {wp, rp, lastd} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        cyc(5'b00101, 18'h00003);
        cyc(5'b00101, 18'h00005);
        cyc(5'b00110, 18'h0);
        cyc(5'b00110, 18'h0);
        repeat (18) cyc(5'b00001, 18'h0);
        cyc(5'b00011, 18'h0);
        repeat (18) cyc(5'b00010, 18'h0);
        for (int k = 0; k < 2; k++) begin
            flag_sync_select <= k[0];
            cyc(5'b00000, 18'h0);
            repeat (60) begin
                rv = rnd();
                cyc({3'b000, rv[1:0]}, 18'h0);
            end
        end
        cyc(5'b10011, 18'h0);
        cyc(5'b00110, 18'h0);
        cyc(5'b00110, 18'h0);
        repeat (5) cyc(5'b00001, 18'h0);
        repeat (3) cyc(5'b00010, 18'h0);
        cyc(5'b01000, 18'h0);
        repeat (6) cyc(5'b00010, 18'h0);
        repeat (3) cyc(5'b00001, 18'h0);
        cyc(5'b00000, 18'h0);
        apb(1'b0, dcf_pkg::REG_COUNT, 32'h0);
        chk("count", 32'(mq.size()), rv);
        apb(1'b1, dcf_pkg::REG_COUNT, 32'hFFFF);
        apb(1'b0, dcf_pkg::REG_COUNT, 32'h0);
        chk("count ro", 32'(mq.size()), rv);
        apb(1'b0, dcf_pkg::REG_STATUS, 32'h0);
        chk("status", 32'h0, {27'h0, rv[4:0]});
        apb(1'b0, dcf_pkg::REG_AE_OFS, 32'h0);
        chk("ae ofs", {14'h0, ofs[0]}, rv);
        apb(1'b1, dcf_pkg::REG_CTRL, 32'h1);
        apb(1'b0, dcf_pkg::REG_CTRL, 32'h0);
        chk("ctrl", 32'h1, rv);
        apb(1'b1, dcf_pkg::REG_CTRL, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h1, {rv[30:0], er});
        psel <= 1'b0;
        @(posedge pclk);
        end_sim();
    end
endmodule

// [rtl/dcf_apb_slave.sv]
/*
 * APB slave: decode, read mux, control register, registered answer with zero wait states.
 * Assumes: a master that holds its request from setup through the access phase.
 */
`timescale 1ns/10ps
module dcf_apb_slave (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire dcf_pkg::dcf_apb_req_t req,
    input  wire dcf_pkg::dcf_stat_t   stat,
    input  wire logic [31:0]          count_word,
    input  wire logic [31:0]          ae_word,
    input  wire logic [31:0]          af_word,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic                      cascade_en
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        ctrl_ff;

    wire setup    = req.sel & ~req.enable;
    wire access   = req.sel & req.enable & pready_ff;
    wire hit_ctrl = req.addr == dcf_pkg::REG_CTRL;
    wire hit_stat = req.addr == dcf_pkg::REG_STATUS;
    wire hit_cnt  = req.addr == dcf_pkg::REG_COUNT;
    wire hit_ae   = req.addr == dcf_pkg::REG_AE_OFS;
    wire hit_af   = req.addr == dcf_pkg::REG_AF_OFS;
    wire mapped   = hit_ctrl | hit_stat | hit_cnt | hit_ae | hit_af;

    wire [31:0] rd_word = hit_ctrl ? {31'h0, ctrl_ff} :
                          hit_stat ? {25'h0, stat} :
                          hit_cnt  ? count_word :
                          hit_ae   ? ae_word :
                          hit_af   ? af_word : 32'h0;

    wire [31:0] nxt_prdata  = setup ? (req.write ? 32'h0 : rd_word) : prdata_ff;
    wire        nxt_pready  = setup;
    wire        nxt_pslverr = setup & ~mapped;
    wire        nxt_ctrl    = (access & req.write & hit_ctrl) ? req.wdata[dcf_pkg::CTRL_CASCADE_BIT] : ctrl_ff;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0;
            pready_ff  <= 1'h0;
            pslverr_ff <= 1'h0;
            ctrl_ff    <= dcf_pkg::CTRL_CASCADE_RST;
        end else begin
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            ctrl_ff    <= nxt_ctrl;
        end
    end

    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = pslverr_ff;
    assign cascade_en = ctrl_ff;

endmodule

// [rtl/dcf_fifo.sv]
/*
 * Top of the 18-bit first-in first-out buffer: pointers, word count, status flags,
 * flag-offset register, retransmit, depth-cascade tokens and the APB register slave.
 * Assumes: write and read ports share pclk; all pins are synchronous to pclk;
 * the read data bus is resolved outside from rd_data and rd_data_oe.
 */
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module dcf_fifo #(
    parameter int          DEPTH      = dcf_pkg::DEPTH_DEF,
    parameter int          ADDR_W     = dcf_pkg::ADDR_W_DEF,
    parameter logic [17:0] AE_OFS_RST = dcf_pkg::AE_OFS_RST,
    parameter logic [17:0] AF_OFS_RST = dcf_pkg::AF_OFS_RST
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        master_reset_n,
    input  wire logic        wr_en_n,
    input  wire logic [17:0] wr_data,
    input  wire logic        rd_en_n,
    input  wire logic        out_en_n,
    output logic      [17:0] rd_data,
    output logic             rd_data_oe,
    input  wire logic        offset_load_n,
    input  wire logic        flag_sync_select,
    input  wire logic        first_load_retransmit,
    input  wire logic        write_cascade_in,
    input  wire logic        read_cascade_in,
    output logic             read_cascade_out,
    output logic             write_cascade_out_half_full,
    output logic             empty_flag_n,
    output logic             full_flag_n,
    output logic             almost_empty_flag_n,
    output logic             almost_full_flag_n
);

    localparam int CNT_W = ADDR_W + 1;
    localparam int DW    = dcf_pkg::DATA_W;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] wr_ptr_ff;
    logic [ADDR_W-1:0] rd_ptr_ff;
    logic [CNT_W-1:0]  count_ff;
    logic [DW-1:0]     ofs_ae_ff;
    logic [DW-1:0]     ofs_af_ff;
    logic              ld_wsel_ff;
    logic              ld_rsel_ff;
    logic [DW-1:0]     rd_data_ff;
    logic              rd_data_oe_ff;
    logic              empty_n_ff;
    logic              full_n_ff;
    logic              ae_n_ff;
    logic              af_n_ff;
    logic              half_n_ff;
    logic              wco_hf_ff;
    logic              rco_ff;
    logic              wr_token_ff;
    logic              rd_token_ff;
    logic              init_pend_ff;
    logic              rt_prev_ff;

    logic [DW-1:0]     mem_rdata;
    logic              cascade_en;

    // ------------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------------
    wire mr       = ~master_reset_n;
    wire wr_ok    = ~cascade_en | wr_token_ff;
    wire rd_ok    = ~cascade_en | rd_token_ff;
    wire is_full  = count_ff == CNT_W'(DEPTH);
    wire is_empty = count_ff == '0;

    // storage write each enabled edge, back to back allowed
    wire wr_mem = ~mr & ~wr_en_n & offset_load_n & ~is_full & wr_ok;

    // retransmit on rising strobe, stand-alone only
    wire rt_req = ~mr & ~cascade_en & ~init_pend_ff & first_load_retransmit & ~rt_prev_ff;

    wire rd_mem = ~mr & ~rt_req & ~rd_en_n & offset_load_n & ~is_empty & rd_ok;

    // offset register access while load is low
    wire ld_wr = ~mr & ~offset_load_n & ~wr_en_n;
    wire ld_rd = ~mr & ~offset_load_n & ~rd_en_n;

    // ------------------------------------------------------------------
    // pointers and count
    // ------------------------------------------------------------------
    wire [ADDR_W-1:0] nxt_wr_ptr = mr ? '0 : wr_ptr_ff + ADDR_W'(wr_mem);
    wire [ADDR_W-1:0] nxt_rd_ptr = (mr | rt_req) ? '0 : rd_ptr_ff + ADDR_W'(rd_mem);

    // retransmit replays the words from location 0 up to the write pointer
    wire [CNT_W-1:0] count_base = rt_req ? CNT_W'(wr_ptr_ff) : count_ff - CNT_W'(rd_mem);
    wire [CNT_W-1:0] nxt_count  = mr ? '0 : count_base + CNT_W'(wr_mem);

    // ------------------------------------------------------------------
    // depth cascade tokens
    // ------------------------------------------------------------------
    wire wr_wrap = cascade_en & wr_mem & (wr_ptr_ff == ADDR_W'(DEPTH - 1));
    wire rd_wrap = cascade_en & rd_mem & (rd_ptr_ff == ADDR_W'(DEPTH - 1));

    // first device (first-load low) starts with both tokens; an arriving token wins over a hand-off
    wire nxt_wr_token = (init_pend_ff | mr) ? ~first_load_retransmit :
                        (write_cascade_in | (wr_token_ff & ~wr_wrap));
    wire nxt_rd_token = (init_pend_ff | mr) ? ~first_load_retransmit :
                        (read_cascade_in | (rd_token_ff & ~rd_wrap));

    // ------------------------------------------------------------------
    // flag-offset register
    // ------------------------------------------------------------------
    // loads alternate: almost-empty offset first, then almost-full offset
    wire [DW-1:0] nxt_ofs_ae = mr ? AE_OFS_RST : (ld_wr & ~ld_wsel_ff) ? wr_data : ofs_ae_ff;
    wire [DW-1:0] nxt_ofs_af = mr ? AF_OFS_RST : (ld_wr & ld_wsel_ff) ? wr_data : ofs_af_ff;
    wire          nxt_ld_wsel = mr ? 1'h0 : ld_wsel_ff ^ ld_wr;
    wire          nxt_ld_rsel = mr ? 1'h0 : ld_rsel_ff ^ ld_rd;
    wire [DW-1:0] ld_rdata    = ld_rsel_ff ? ofs_af_ff : ofs_ae_ff;

    // ------------------------------------------------------------------
    // read data path
    // ------------------------------------------------------------------
    wire [DW-1:0] nxt_rd_data = mr     ? '0 :
                                rd_mem ? mem_rdata :
                                ld_rd  ? ld_rdata :
                                rd_data_ff;
    wire          nxt_rd_data_oe = ~out_en_n;

    // ------------------------------------------------------------------
    // flags
    // ------------------------------------------------------------------
    wire nxt_empty_n = nxt_count != '0;
    wire nxt_full_n  = nxt_count != CNT_W'(DEPTH);
    wire nxt_half_n  = ~(nxt_count > CNT_W'(DEPTH / 2));

    // strap high follows the new count at once, strap low trails by one edge
    wire [17:0] lvl_src  = flag_sync_select ? 18'(nxt_count) : 18'(count_ff);
    wire [17:0] free_src = 18'(DEPTH) - lvl_src;
    wire nxt_ae_n = mr ? 1'h0 : ~dcf_pkg::dcf_at_or_below(lvl_src, ofs_ae_ff);
    wire nxt_af_n = mr ? 1'h1 : ~dcf_pkg::dcf_at_or_below(free_src, ofs_af_ff);

    // shared pin: half-full alone, write expansion pulse when cascaded
    wire nxt_wco_hf = cascade_en ? (wr_wrap & ~mr) : nxt_half_n;
    wire nxt_rco    = rd_wrap & ~mr;

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    dcf_mem #(
        .W     (DW),
        .DEPTH (DEPTH),
        .AW    (ADDR_W)
    ) u_mem (
        .clk   (pclk),
        .we    (wr_mem),
        .waddr (wr_ptr_ff),
        .wdata (wr_data),
        .raddr (rd_ptr_ff),
        .rdata (mem_rdata)
    );

    // ------------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------------
    dcf_pkg::dcf_apb_req_t apb_req;
    dcf_pkg::dcf_stat_t    stat;

    assign apb_req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
    assign stat    = '{rd_token: rd_token_ff, wr_token: wr_token_ff, full: ~full_n_ff,
                       almost_full: ~af_n_ff, half: ~half_n_ff, almost_empty: ~ae_n_ff,
                       empty: ~empty_n_ff};

    dcf_apb_slave u_apb (
        .pclk       (pclk),
        .presetn    (presetn),
        .req        (apb_req),
        .stat       (stat),
        .count_word (32'(count_ff)),
        .ae_word    (32'(ofs_ae_ff)),
        .af_word    (32'(ofs_af_ff)),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .cascade_en (cascade_en)
    );

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_ff     <= '0;
            rd_ptr_ff     <= '0;
            count_ff      <= '0;
            ofs_ae_ff     <= AE_OFS_RST;
            ofs_af_ff     <= AF_OFS_RST;
            ld_wsel_ff    <= 1'h0;
            ld_rsel_ff    <= 1'h0;
            rd_data_ff    <= '0;
            rd_data_oe_ff <= 1'h0;
            init_pend_ff  <= 1'h1;
            rt_prev_ff    <= 1'h0;
            wr_token_ff   <= 1'h0;
            rd_token_ff   <= 1'h0;
        end else begin
            wr_ptr_ff     <= nxt_wr_ptr;
            rd_ptr_ff     <= nxt_rd_ptr;
            count_ff      <= nxt_count;
            ofs_ae_ff     <= nxt_ofs_ae;
            ofs_af_ff     <= nxt_ofs_af;
            ld_wsel_ff    <= nxt_ld_wsel;
            ld_rsel_ff    <= nxt_ld_rsel;
            rd_data_ff    <= nxt_rd_data;
            rd_data_oe_ff <= nxt_rd_data_oe;
            init_pend_ff  <= 1'h0;
            rt_prev_ff    <= first_load_retransmit;
            wr_token_ff   <= nxt_wr_token;
            rd_token_ff   <= nxt_rd_token;
        end
    end

    // flag registers, reset to the empty picture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            empty_n_ff <= 1'h0;
            ae_n_ff    <= 1'h0;
            full_n_ff  <= 1'h1;
            af_n_ff    <= 1'h1;
            half_n_ff  <= 1'h1;
            wco_hf_ff  <= 1'h1;
            rco_ff     <= 1'h0;
        end else begin
            empty_n_ff <= nxt_empty_n;
            ae_n_ff    <= nxt_ae_n;
            full_n_ff  <= nxt_full_n;
            af_n_ff    <= nxt_af_n;
            half_n_ff  <= nxt_half_n;
            wco_hf_ff  <= nxt_wco_hf;
            rco_ff     <= nxt_rco;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rd_data                     = rd_data_ff;
    assign rd_data_oe                  = rd_data_oe_ff;
    assign empty_flag_n                = empty_n_ff;
    assign full_flag_n                 = full_n_ff;
    assign almost_empty_flag_n         = ae_n_ff;
    assign almost_full_flag_n          = af_n_ff;
    assign write_cascade_out_half_full = wco_hf_ff;
    assign read_cascade_out            = rco_ff;

endmodule

// [rtl/dcf_mem.sv]
/*
 * Storage array of the buffer: one synchronous write port, one combinational read port.
 * Assumes: the caller never writes a location that it reads as valid in the same cycle.
 */
`timescale 1ns/10ps
module dcf_mem #(
    parameter int W     = 18,
    parameter int DEPTH = 32768,
    parameter int AW    = 15
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);

    logic [W-1:0] mem [0:DEPTH-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];

endmodule

// [shared/dcf_pkg.sv]
/*
 * Shared constants, types and helpers for the 18-bit first-in first-out buffer.
 * Assumes: one clock domain (pclk), APB register slave, all pins sampled on pclk.
 */
// Summary of operation
// - Write pulse with write enable low and buffer not full stores the data word.
// - Read pulse with read enable low and not empty outputs and removes oldest word.
// - Held write enable accepts one word every clock, no gaps needed.
// - Offset load low steers data buses to the flag-offset register instead of storage.
// - Offset load low plus write writes data bus into flag-offset register.
// - Offset load low plus read puts flag-offset register on read data bus.
// - Empty flag low exactly when buffer empty, updated on read clock.
// - Full flag low exactly when no free location, updated on write clock.
// - Almost-empty low when stored count at or below almost-empty offset.
// - Almost-full low when free space at or below almost-full offset.
// - Strap high: almost flags follow the count with no extra edge.
// - Strap low: almost-empty updates only on read clock edges.
// - Strap low: almost-full updates only on write clock edges.
// - Half-full pin is half-full flag alone, write expansion output when cascaded.
// - Retransmit strobe in stand-alone mode makes read data available again.
// - Reset empties buffer, discarding contents and clearing read and write positions.
// - Output enable low drives read data bus; high leaves it released.
package dcf_pkg;

    // ------------------------------------------------------------------
    // sizes and reset values
    // ------------------------------------------------------------------
    localparam int          DATA_W      = 18;
    localparam int          DEPTH_DEF   = 32768;
    localparam int          ADDR_W_DEF  = 15;
    localparam logic [17:0] AE_OFS_RST  = 18'h0007F;
    localparam logic [17:0] AF_OFS_RST  = 18'h0007F;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int          APB_AW      = 8;
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_STATUS  = 8'h04;
    localparam logic [7:0]  REG_COUNT   = 8'h08;
    localparam logic [7:0]  REG_AE_OFS  = 8'h0C;
    localparam logic [7:0]  REG_AF_OFS  = 8'h10;
    localparam int          CTRL_CASCADE_BIT = 0;
    localparam logic        CTRL_CASCADE_RST = 1'h0;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } dcf_apb_req_t;

    // active-high view of the flags, bit 0 is empty
    typedef struct packed {
        logic rd_token;
        logic wr_token;
        logic full;
        logic almost_full;
        logic half;
        logic almost_empty;
        logic empty;
    } dcf_stat_t;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic dcf_at_or_below(input logic [17:0] level, input logic [17:0] ofs);
        return level <= ofs;
    endfunction

endpackage
